// *** src/svr_pkg.sv ***
// Operation
// - undervoltage sets flag and asserts internal reset
// - undervoltage path stays active in stop mode
// - defer undervoltage reset until RAM write ends
// - suppress undervoltage request while reset is driven
// - runaway counter is 20 bits on oscillation clock
// - counter starts by itself after power-on reset
// - uncleared full interval raises internal reset
// - runaway reset lasts five machine cycles
// - standby recovery extends period by twenty microseconds
package svr_pkg;
    localparam int unsigned CLOCK_HZ     = 10_000_000;       // machine and count clock rate
    localparam int unsigned COUNT_WIDTH  = 20;               // runaway counter width
    localparam int unsigned PULSE_CYCLES = 5;                // runaway reset width
    localparam int unsigned EXTEND_NS    = 20_000;           // standby extension, in ns
    // extension in whole cycles; exact only while the clock is a whole number of MHz
    localparam int unsigned EXTEND_CYCLES = (EXTEND_NS / 1_000) * (CLOCK_HZ / 1_000_000);
    localparam logic [2:0]  PULSE_W       = 3'(PULSE_CYCLES);  // pulse count at counter width
    localparam logic [7:0]  EXTEND_W      = 8'(EXTEND_CYCLES); // extension at register width
    localparam logic        FLAG_RESET    = 1'b0;            // flag value at power-on
endpackage

// *** src/svr_pulse.sv ***
`timescale 1ns/1ps
`default_nettype none
// fixed-width pulse stretcher for the runaway reset
module svr_pulse
    import svr_pkg::*;
(
    input  wire logic clock,  // machine clock
    input  wire logic reset,  // power-on reset, async high
    input  wire logic fire,   // one-cycle start
    output logic      active  // pulse output, registered
);
    typedef struct packed {
        logic [2:0] left;     // cycles still to drive
        logic       active;   // pulse level
    } svr_pulse_s;

    svr_pulse_s st;           // current state
    svr_pulse_s next_st;      // next state

    // count down while the pulse stands
    always_comb begin
        next_st = st;
        if (st.left != 3'h0) begin
            next_st.left = st.left - 3'h1;
        end else if (fire) begin
            next_st.left = PULSE_W;
        end
        next_st.active = (next_st.left != 3'h0);
    end

    // state register
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign active = st.active;

    pulse_width_a: assert property (@(posedge clock) disable iff (reset)
        $rose(active) |-> active [*5] ##1 !active)
        else $error("runaway reset pulse not five cycles");
endmodule
`default_nettype wire

// *** src/svr_top.sv ***
`timescale 1ns/1ps
`default_nettype none
// undervoltage reset path and runaway counter sharing one internal reset
module svr_top
    import svr_pkg::*;
#(
    parameter int unsigned WIDTH = COUNT_WIDTH  // runaway counter width
) (
    input  wire logic clock,             // oscillation / machine clock, 10 MHz
    input  wire logic reset,             // power-on reset, async high
    input  wire logic undervoltage,      // comparator says supply is low
    input  wire logic stop_mode,         // core is in stop mode
    input  wire logic ram_write_busy,    // internal RAM write in progress
    input  wire logic counter_clear,     // software clear pulse
    input  wire logic flag_clear,        // software clears undervoltage flag
    input  wire logic standby_return,    // pulse: leaving standby
    output logic      undervoltage_flag, // reset cause flag, registered
    output logic      internal_reset,    // internal reset request, OR of two registered causes
    output logic      stop_release,      // wake from stop mode, registered
    output logic      runaway_reset      // runaway pulse, registered
);
    import svr_pkg::*;

    // all state of both reset paths except the runaway pulse stretcher, registered as one word
    typedef struct packed {
        logic [WIDTH-1:0] count;     // runaway counter
        logic [7:0]       extend;    // standby extension cycles left
        logic             flag;      // undervoltage flag
        logic             uv_pend;   // undervoltage waiting for RAM write
        logic             uv_reset;  // undervoltage reset level
        logic             wake;      // stop release
    } svr_top_s;

    svr_top_s st;            // current state
    svr_top_s next_st;       // next state
    logic     expire;        // interval fully elapsed
    logic     pulse_active;  // runaway pulse from stretcher
    logic     busy_reset;    // a reset already being driven
    logic     uv_request;    // undervoltage seen now or parked
    logic     full;          // counter at its terminal value

    // terminal test, shared by the counter, the expiry and the checks
    function automatic logic at_terminal(input logic [WIDTH-1:0] value);
        return &value;
    endfunction

    // a reset already on the line swallows fresh undervoltage requests unless a RAM write parks them
    assign busy_reset = pulse_active | st.uv_reset;
    // a request seen this cycle or parked behind a RAM write
    assign uv_request = undervoltage | st.uv_pend;
    assign full       = at_terminal(st.count);
    // a clear in the very last cycle still rescues the program
    assign expire     = full && (st.extend == 8'h00) && !counter_clear;

    // next-state logic for both paths
    always_comb begin
        next_st = st;
        // counter free-runs from reset release, no enable needed
        if (counter_clear || pulse_active) begin
            // a clear restarts the full interval, the pulse holds it at zero
            next_st.count = '0;
        end else if (full) begin
            // hold at terminal count while the standby extension drains
            if (st.extend != 8'h00) begin
                next_st.extend = st.extend - 8'h01;
            end else begin
                next_st.count = '0;
            end
        end else begin
            next_st.count = st.count + 1'b1;
        end
        // slow clock start after standby gets a longer first interval
        if (standby_return) begin
            next_st.extend = EXTEND_W;
        end
        // undervoltage request, held back during RAM writes
        next_st.uv_reset = 1'b0;
        next_st.wake     = 1'b0;
        if (uv_request) begin
            if (ram_write_busy) begin
                // a half-written word would survive the reset as garbage
                next_st.uv_pend = 1'b1;
            end else if (busy_reset) begin
                // dropped, not queued: the running reset already covers it
                next_st.uv_pend = 1'b0;
            end else begin
                // one reset cycle per accepted request
                next_st.uv_pend  = 1'b0;
                next_st.uv_reset = 1'b1;
                next_st.wake     = stop_mode;
            end
        end
        // set beats clear so a detection is never lost
        if (flag_clear) begin
            next_st.flag = 1'b0;
        end
        if (undervoltage) begin
            next_st.flag = 1'b1;
        end
    end

    // state register
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            st      <= '0;
            st.flag <= FLAG_RESET;
        end else begin
            st <= next_st;
        end
    end

    // stretcher for the runaway reset
    svr_pulse u_pulse (
        .clock  (clock),
        .reset  (reset),
        .fire   (expire),
        .active (pulse_active)
    );

    // outputs straight from flip-flops, the stretcher output included; internal reset is an OR of two of them
    // internal reset is the union of both causes
    assign undervoltage_flag = st.flag;
    assign internal_reset    = st.uv_reset | pulse_active;
    assign stop_release      = st.wake;
    assign runaway_reset     = pulse_active;

    flag_set_a: assert property (@(posedge clock) disable iff (reset)
        undervoltage |=> undervoltage_flag)
        else $error("flag not set on undervoltage");
    uv_reset_a: assert property (@(posedge clock) disable iff (reset)
        (undervoltage && !ram_write_busy && !busy_reset && !st.uv_pend) |=> internal_reset)
        else $error("undervoltage reset missing");
    stop_wake_a: assert property (@(posedge clock) disable iff (reset)
        (undervoltage && stop_mode && !ram_write_busy && !busy_reset) |=> stop_release)
        else $error("stop mode not released");
    ram_defer_a: assert property (@(posedge clock) disable iff (reset)
        ram_write_busy |=> !st.uv_reset)
        else $error("reset during RAM write");
    suppress_a: assert property (@(posedge clock) disable iff (reset)
        (pulse_active && !ram_write_busy) |=> !st.uv_reset)
        else $error("undervoltage reset not suppressed");
    clear_zero_a: assert property (@(posedge clock) disable iff (reset)
        counter_clear |=> st.count == '0)
        else $error("clear did not zero counter");
    flag_hold_a: assert property (@(posedge clock) disable iff (reset)
        (undervoltage_flag && !flag_clear) |=> undervoltage_flag)
        else $error("flag dropped without clear");
    count_run_a: assert property (@(posedge clock) disable iff (reset)
        (!counter_clear && !pulse_active && !(&st.count)) |=> st.count == $past(st.count) + 1'b1)
        else $error("counter not advancing");
    expire_a: assert property (@(posedge clock) disable iff (reset)
        expire |=> runaway_reset)
        else $error("expiry without reset");

    // further checks on both reset paths
    // stop release only rides on an undervoltage reset
    wake_only_a: assert property (@(posedge clock) disable iff (reset)
        stop_release |-> internal_reset)
        else $error("stop release without reset");

    // no wake pulse when the core is running
    stop_quiet_a: assert property (@(posedge clock) disable iff (reset)
        !stop_mode |=> !stop_release)
        else $error("stop release outside stop mode");

    // no undervoltage reset without a request
    idle_quiet_a: assert property (@(posedge clock) disable iff (reset)
        (!undervoltage && !st.uv_pend) |=> !st.uv_reset)
        else $error("undervoltage reset without cause");

    // a parked request waits as long as the write lasts
    pend_hold_a: assert property (@(posedge clock) disable iff (reset)
        (st.uv_pend && ram_write_busy) |=> st.uv_pend)
        else $error("parked request lost during write");

    // a parked request fires once the write is over
    pend_release_a: assert property (@(posedge clock) disable iff (reset)
        (st.uv_pend && !ram_write_busy && !busy_reset) |=> internal_reset)
        else $error("parked request never fired");

    // requests during a running reset with no RAM write are dropped, not parked
    drop_no_queue_a: assert property (@(posedge clock) disable iff (reset)
        (undervoltage && busy_reset && !ram_write_busy) |=> !st.uv_pend)
        else $error("suppressed request was queued");

    // counter stays at zero while the runaway pulse stands
    pulse_hold_a: assert property (@(posedge clock) disable iff (reset)
        pulse_active |=> st.count == '0)
        else $error("counter ran during runaway pulse");

    // expiry wraps the counter
    terminal_wrap_a: assert property (@(posedge clock) disable iff (reset)
        expire |=> st.count == '0)
        else $error("counter not wrapped on expiry");

    // runaway pulse only ever follows an expiry
    runaway_only_a: assert property (@(posedge clock) disable iff (reset)
        $rose(runaway_reset) |-> $past(expire))
        else $error("runaway reset without expiry");

    // leaving standby arms the full extension
    extend_load_a: assert property (@(posedge clock) disable iff (reset)
        standby_return |=> st.extend == EXTEND_W)
        else $error("standby extension not armed");

    // terminal count holds while extension cycles remain
    terminal_hold_a: assert property (@(posedge clock) disable iff (reset)
        (full && st.extend != 8'h00 && !counter_clear && !pulse_active) |=> full)
        else $error("counter left terminal during extension");

    // the extension drains one cycle at a time
    extend_drain_a: assert property (@(posedge clock) disable iff (reset)
        (full && st.extend != 8'h00 && !counter_clear && !pulse_active && !standby_return)
        |=> st.extend == $past(st.extend) - 8'h01)
        else $error("extension not draining");

    // an explicit clear with no new detection drops the flag
    flag_clear_a: assert property (@(posedge clock) disable iff (reset)
        (flag_clear && !undervoltage) |=> !undervoltage_flag)
        else $error("flag not cleared");

    // the flag never sets on its own
    flag_quiet_a: assert property (@(posedge clock) disable iff (reset)
        (!undervoltage_flag && !undervoltage) |=> !undervoltage_flag)
        else $error("flag set without undervoltage");
endmodule
`default_nettype wire

// *** tb/svr_core_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// core model: software clears the runaway counter on a fixed period
module svr_core_model #(
    parameter int unsigned PERIOD = 100  // cycles between clears, below the interval
) (
    input  wire logic clock,         // machine clock
    input  wire logic reset,         // power-on reset
    input  wire logic kick_en,       // program alive and kicking
    output logic      counter_clear  // one-cycle clear pulse
);
    int unsigned cnt;  // cycles since last clear
    // a stalled program is modelled by dropping kick_en, not by odd pulses
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            cnt           <= 0;
            counter_clear <= 1'b0;
        end else begin
            cnt           <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
            counter_clear <= kick_en && (cnt == PERIOD - 1);
        end
    end
endmodule
`default_nettype wire

// *** tb/test_svr_top.sv ***
`timescale 1ns/1ps
`default_nettype none
// bench for the undervoltage and runaway reset block
module test_svr_top;
    import svr_pkg::*;
    localparam int unsigned W = 8;  // short counter, interval of 256 cycles
    logic       clock = 1'b0, reset = 1'b1, uv = 1'b0, stop = 1'b0, busy = 1'b0;
    logic       fclr  = 1'b0, sret  = 1'b0, kick = 1'b0;  // bench-driven inputs
    logic       flag, irst, rel, rrst, cclr;               // block outputs, clear
    int         miscompares = 0, n_checks = 0, cyc = 0, t; // tallies
    // rows: undervoltage, stop, busy -> flag, internal reset, stop release
    // the flag is set at once even when the reset waits for a write
    logic [5:0] rows [4] = '{6'h00, 6'h26, 6'h37, 6'h2C};
    localparam int SEL_RR = 0;  // watch runaway reset
    localparam int SEL_IR = 1;  // watch internal reset
    localparam int SEL_CC = 2;  // watch the model's clear
    always #50 clock = ~clock;
    svr_top #(.WIDTH(W)) dut (.clock(clock), .reset(reset), .undervoltage(uv),
        .stop_mode(stop), .ram_write_busy(busy), .counter_clear(cclr), .flag_clear(fclr),
        .standby_return(sret), .undervoltage_flag(flag), .internal_reset(irst),
        .stop_release(rel), .runaway_reset(rrst));
    svr_core_model core (.clock(clock), .reset(reset), .kick_en(kick), .counter_clear(cclr));
    // verdict and stop, the only exit
    task automatic end_sim;
        if (miscompares == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // inputs move 1 ns after the edge, outputs are read there too
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    // the output a bounded wait watches
    function automatic logic pick(input int which);
        if (which == SEL_RR) return rrst;
        else if (which == SEL_IR) return irst;
        else return cclr;
    endfunction
    // bounded wait for a high level, n is cycles spent
    task automatic wait_hi(input int which, input int lim, output int n);
        n = 0;
        while (pick(which) !== 1'b1 && n < lim) begin
            step(1);
            n++;
        end
    endtask
    // hang guard, well above the planned run
    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            end_sim();
        end
    end
    initial begin
        step(10);
        chk({12'h000, flag, irst, rel, rrst}, 16'h0000);
        reset = 1'b0;
        wait_hi(SEL_RR, 400, t);  // no clears at all after release
        chk(16'(t), 16'(2 ** W));
        uv = 1'b1;  // undervoltage during the runaway pulse is dropped
        t = 0;
        while (rrst === 1'b1 && t < 20) begin
            chk({15'h0000, irst}, 16'h0001);
            step(1);
            uv = 1'b0;
            t++;
        end
        chk(16'(t), 16'h0005);
        step(2);
        chk({15'h0000, irst}, 16'h0000);
        kick = 1'b1;
        // ordinary cases, flag cleared before each
        foreach (rows[i]) begin
            fclr = 1'b1;
            step(1);
            {uv, stop, busy} = rows[i][5:3];
            fclr = 1'b0;
            step(1);
            chk({13'h0000, flag, irst, rel}, {13'h0000, rows[i][2:0]});
            uv = 1'b0;
            stop = 1'b0;
            step(4);
        end
        chk({15'h0000, irst}, 16'h0000);
        busy = 1'b0;  // write done, the held-off reset follows
        wait_hi(SEL_IR, 3, t);
        chk({15'h0000, flag}, 16'h0001);
        chk(16'(t < 3), 16'h0001);
        step(6);
        chk({15'h0000, flag}, 16'h0001);
        fclr = 1'b1;
        step(1);
        fclr = 1'b0;
        step(1);
        chk({15'h0000, flag}, 16'h0000);
        wait_hi(SEL_RR, 700, t);  // periodic clears keep the counter away
        chk(16'(t), 16'h02BC);
        wait_hi(SEL_CC, 200, t);
        kick = 1'b0;
        sret = 1'b1;
        step(1);
        sret = 1'b0;
        wait_hi(SEL_RR, 1000, t);
        chk(16'(t), 16'(2 ** W + EXTEND_CYCLES));
        step(10);
        end_sim();
    end
endmodule
`default_nettype wire
